// *** verilog/epv_pkg.sv ***
/*
  Package for the exception priority and vectoring block: register map,
  field layout, reset values, exception numbers, priority constants and bus states.
  Assumes a 32-bit Avalon-MM register slave; priority registers sit one per byte address from EPV_OFS_PRIO0.
*/
package epv_pkg;
  localparam int EPV_NUM_EXC = 64;
  localparam int EPV_NUM_IRQ = 48;
  localparam int EPV_FIRST_IRQ = 16;
  localparam int EPV_PRIO_W = 3;
  localparam int EPV_EXC_W = 6;
  localparam int EPV_ADDR_W = 8;

  localparam logic [EPV_EXC_W-1:0] EPV_EXC_NONE = 6'h00;
  localparam logic [EPV_EXC_W-1:0] EPV_EXC_RESET = 6'h01;
  localparam logic [EPV_EXC_W-1:0] EPV_EXC_NMI = 6'h02;
  localparam logic [EPV_EXC_W-1:0] EPV_EXC_HARD = 6'h03;

  // byte offsets of the registers
  localparam logic [EPV_ADDR_W-1:0] EPV_OFS_VECBASE = 8'h00;
  localparam logic [EPV_ADDR_W-1:0] EPV_OFS_GROUP = 8'h04;
  localparam logic [EPV_ADDR_W-1:0] EPV_OFS_ACTIVE = 8'h08;
  localparam logic [EPV_ADDR_W-1:0] EPV_OFS_STATUS = 8'h0C;
  localparam logic [EPV_ADDR_W-1:0] EPV_OFS_PRIO0 = 8'h40;

  localparam logic [31:0] EPV_VECBASE_RESET = 32'h0000_0000;
  localparam logic [31:0] EPV_VECBASE_MIN = 32'h0000_0100;
  localparam logic [31:0] EPV_VECBASE_MAX = 32'h3FFF_FF00;
  localparam int EPV_VECBASE_LSB = 8;
  localparam logic [2:0] EPV_GROUP_RESET = 3'h0;
  localparam logic [EPV_PRIO_W-1:0] EPV_PRIO_RESET = 3'h0;
  localparam int EPV_VEC_STRIDE_SH = 2;
  localparam logic [31:0] EPV_UNMAPPED_DATA = 32'h0000_0000;
  // fixed urgency of the three highest exceptions, below any settable value
  localparam logic [4:0] EPV_RANK_RESET = 5'h00;
  localparam logic [4:0] EPV_RANK_NMI = 5'h01;
  localparam logic [4:0] EPV_RANK_HARD = 5'h02;
  localparam logic [4:0] EPV_RANK_BIAS = 5'h03;
  localparam logic [4:0] EPV_RANK_IDLE = 5'h1F;

  typedef enum logic [2:0] {
    EPV_BUS_IDLE = 3'b001,
    EPV_BUS_ACK = 3'b010,
    EPV_BUS_DONE = 3'b100
  } epv_bus_state_t;
endpackage

// *** verilog/epv_prio_split.sv ***
/*
  Splits a three-bit priority into group and subpriority by the grouping value.
  Assumes the grouping value gives the number of subpriority bits, 0 to 3.
*/
`timescale 1ns/1ps
`default_nettype none
module epv_prio_split
  import epv_pkg::*;
(
  input wire logic [EPV_PRIO_W-1:0] prio,
  input wire logic [2:0] group_sel,
  output logic [EPV_PRIO_W-1:0] group_prio,
  output logic [EPV_PRIO_W-1:0] sub_prio
);
  logic [EPV_PRIO_W-1:0] sub_mask;

  always_comb begin
    case (group_sel)
      3'h0: sub_mask = 3'h0;
      3'h1: sub_mask = 3'h1;
      3'h2: sub_mask = 3'h3;
      default: sub_mask = 3'h7;
    endcase
    group_prio = prio & ~sub_mask;
    sub_prio = prio & sub_mask;
  end
endmodule
`default_nettype wire

// *** verilog/epv_vector_addr.sv ***
/*
  Forms the vector table word address for an exception number.
  Assumes the base is 256-byte aligned, so the stride adds without carry out.
*/
`timescale 1ns/1ps
`default_nettype none
module epv_vector_addr
  import epv_pkg::*;
(
  input wire logic [31:0] base,
  input wire logic [EPV_EXC_W-1:0] exc_num,
  output logic [31:0] addr
);
  always_comb begin
    addr = base + {24'h00_0000, exc_num, 2'b00};
  end
endmodule
`default_nettype wire

// *** verilog/epv_top.sv ***
/*
  Exception priority and vectoring logic: vector base, settable priorities,
  priority grouping, pending arbitration and preemption decision.
  Assumes an Avalon-MM master, a core that reports its active exception and
  privilege, and interrupt lines that are synchronous to CLK.
*/
// Contract
// R1 - vector table holds reset stack pointer then handler addresses by number
// R2 - software sets bit zero of each handler address to one
// R3 - after reset the vector table base is address zero
// R4 - privileged writes relocate the base within the allowed window
// R5 - software writes a base aligned to 256 bytes
// R6 - smaller priority is more urgent; reset, hard fault, NMI not settable
// R7 - settable priorities reset to zero
// R8 - settable priorities span zero to seven; fixed ones always win
// R9 - equal priority: smallest exception number first
// R10 - strictly more urgent exception preempts the active handler
// R11 - equal priority never preempts; it stays pending
// R12 - priority entries split into group and subpriority by grouping value
// R13 - preemption decided by group priority alone
// R14 - equal group: more urgent subpriority first
// R15 - equal group and subpriority: smallest number first
// R16 - stack pointer from word zero, handlers at four-byte spacing
// R17 - arbitrate combinationally, register winner and preemption decision
`timescale 1ns/1ps
`default_nettype none
module epv_top
  import epv_pkg::*;
#(
  parameter int NUM_IRQ = EPV_NUM_IRQ
)(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [EPV_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic PRIV_WRITE,
  input wire logic [NUM_IRQ-1:0] PERIPHERAL_INTERRUPT_LINE,
  input wire logic [EPV_FIRST_IRQ-1:0] SYS_EXC_PENDING,
  input wire logic [EPV_EXC_W-1:0] ACTIVE_EXC,
  output logic [EPV_EXC_W-1:0] WIN_EXC,
  output logic WIN_VALID,
  output logic WIN_PREEMPT,
  output logic [31:0] WIN_VECTOR_ADDR,
  output logic [31:0] RESET_SP_ADDR
);
  // the ordering checks below look at the first two interrupt lines
  if (NUM_IRQ < 2 || NUM_IRQ > EPV_NUM_IRQ) begin : g_bad_num_irq
    $error("NUM_IRQ out of range");
  end

  localparam int NEXC = EPV_FIRST_IRQ + NUM_IRQ;

  // ---------------- register file ----------------
  logic [31:0] vec_base, next_vec_base;
  logic [2:0] group_sel, next_group_sel;
  logic [EPV_PRIO_W-1:0] prio [NEXC];
  logic [EPV_PRIO_W-1:0] next_prio [NEXC];
  epv_bus_state_t bus_state, next_bus_state;
  logic [31:0] rdata, next_rdata;
  logic [EPV_EXC_W-1:0] win_exc, next_win_exc;
  logic win_valid, next_win_valid, win_preempt, next_win_preempt;

  function automatic logic exc_settable(input int n);
    return n > 3;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction

  logic take;
  logic wr_commit;
  logic [31:0] base_cand;
  assign take = bus_state == EPV_BUS_IDLE && (AVS_READ || AVS_WRITE);
  assign wr_commit = bus_state == EPV_BUS_ACK && AVS_WRITE;
  assign base_cand = be_merge(vec_base, AVS_WRITEDATA, AVS_BYTEENABLE)
                     & ~((32'h0000_0001 << EPV_VECBASE_LSB) - 32'h0000_0001);

  always_comb begin
    next_vec_base = vec_base;
    next_group_sel = group_sel;
    next_prio = prio;
    next_rdata = rdata;
    next_bus_state = bus_state;
    case (bus_state)
      EPV_BUS_IDLE: begin
        if (take) next_bus_state = EPV_BUS_ACK;
        if (take && AVS_READ) begin
          next_rdata = EPV_UNMAPPED_DATA;
          case (AVS_ADDRESS)
            EPV_OFS_VECBASE: next_rdata = vec_base;
            EPV_OFS_GROUP: next_rdata = {29'h0000_0000, group_sel};
            EPV_OFS_ACTIVE: next_rdata = {26'h000_0000, ACTIVE_EXC};
            EPV_OFS_STATUS: next_rdata = {24'h00_0000, win_preempt, win_valid, win_exc};
            default: begin
              for (int i = 4; i < NEXC; i++) begin
                if (AVS_ADDRESS == EPV_OFS_PRIO0 + 8'(i)) begin
                  next_rdata = {29'h0000_0000, prio[i]};
                end
              end
            end
          endcase
        end
      end
      EPV_BUS_ACK: begin
        next_bus_state = EPV_BUS_DONE;
        // writes land at the edge that sees waitrequest low
        if (wr_commit) begin
          if (AVS_ADDRESS == EPV_OFS_VECBASE && PRIV_WRITE
              && base_cand >= EPV_VECBASE_MIN && base_cand <= EPV_VECBASE_MAX) begin
            next_vec_base = base_cand; // R4
          end
          if (AVS_ADDRESS == EPV_OFS_GROUP && AVS_BYTEENABLE[0]) begin
            next_group_sel = AVS_WRITEDATA[2:0]; // R12
          end
          for (int i = 4; i < NEXC; i++) begin
            if (AVS_ADDRESS == EPV_OFS_PRIO0 + 8'(i) && exc_settable(i)
                && AVS_BYTEENABLE[0]) begin
              next_prio[i] = AVS_WRITEDATA[EPV_PRIO_W-1:0]; // R6 R8
            end
          end
        end
      end
      EPV_BUS_DONE: next_bus_state = EPV_BUS_IDLE;
      default: next_bus_state = EPV_BUS_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      vec_base <= EPV_VECBASE_RESET; // R3
      group_sel <= EPV_GROUP_RESET;
      for (int i = 0; i < NEXC; i++) prio[i] <= EPV_PRIO_RESET; // R7
      rdata <= 32'h0000_0000;
      bus_state <= EPV_BUS_IDLE;
    end else begin
      vec_base <= next_vec_base;
      group_sel <= next_group_sel;
      prio <= next_prio;
      rdata <= next_rdata;
      bus_state <= next_bus_state;
    end
  end

  // request taken in IDLE, answered one cycle later
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && bus_state != EPV_BUS_ACK;
  assign AVS_READDATA = rdata;

  // ---------------- arbitration ----------------
  logic [EPV_PRIO_W-1:0] grp [NEXC];
  logic [EPV_PRIO_W-1:0] sub [NEXC];
  logic [NEXC-1:0] pend;

  assign pend = {PERIPHERAL_INTERRUPT_LINE, SYS_EXC_PENDING};

  for (genvar g = 0; g < NEXC; g++) begin : g_split
    epv_prio_split u_split (
      .prio(prio[g]),
      .group_sel(group_sel),
      .group_prio(grp[g]),
      .sub_prio(sub[g])
    ); // R12
  end

  // fixed exceptions rank below every settable group value
  function automatic logic [4:0] rank_of(input int n, input logic [EPV_PRIO_W-1:0] g);
    case (n)
      1: return EPV_RANK_RESET;
      2: return EPV_RANK_NMI;
      3: return EPV_RANK_HARD;
      default: return EPV_RANK_BIAS + 5'(g);
    endcase
  endfunction

  logic [4:0] best_rank, act_rank;
  logic [EPV_PRIO_W-1:0] best_sub;
  logic [EPV_EXC_W-1:0] best_num;
  logic best_found;

  always_comb begin
    best_rank = EPV_RANK_IDLE;
    best_sub = 3'h7;
    best_num = EPV_EXC_NONE;
    best_found = 1'b0;
    act_rank = EPV_RANK_IDLE;
    for (int i = 1; i < NEXC; i++) begin
      if (ACTIVE_EXC == 6'(i)) act_rank = rank_of(i, grp[i]); // R13
      // ascending scan with strict compare keeps the lowest number on ties
      if (pend[i] && (!best_found || rank_of(i, grp[i]) < best_rank // R6 R9
          || (rank_of(i, grp[i]) == best_rank && sub[i] < best_sub))) begin // R14 R15
        best_found = 1'b1;
        best_rank = rank_of(i, grp[i]);
        best_sub = sub[i];
        best_num = 6'(i);
      end
    end
    next_win_exc = best_num;
    next_win_valid = best_found;
    next_win_preempt = best_found && best_rank < act_rank; // R10 R11
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      win_exc <= EPV_EXC_NONE;
      win_valid <= 1'b0;
      win_preempt <= 1'b0;
    end else begin
      win_exc <= next_win_exc; // R17
      win_valid <= next_win_valid;
      win_preempt <= next_win_preempt;
    end
  end

  assign WIN_EXC = win_exc;
  assign WIN_VALID = win_valid;
  assign WIN_PREEMPT = win_preempt;

  epv_vector_addr u_vec (
    .base(vec_base),
    .exc_num(win_exc),
    .addr(WIN_VECTOR_ADDR)
  ); // R1 R16
  assign RESET_SP_ADDR = vec_base; // R16

  // ---------------- assertions ----------------
  sequence s_vb_write;
    wr_commit && AVS_ADDRESS == EPV_OFS_VECBASE;
  endsequence

  sequence s_fixed_prio_write;
    wr_commit && AVS_ADDRESS == EPV_OFS_PRIO0 + 8'h03;
  endsequence

  sequence s_thread_pending;
    ACTIVE_EXC == EPV_EXC_NONE && pend[NEXC-1:1] != '0;
  endsequence

  AST_RESET_BASE: assert property (@(posedge CLK) $past(RST) |-> vec_base == 32'h0) // R3
    else $error("vector base not zero after reset");
  AST_UNPRIV_IGNORED: assert property (@(posedge CLK) disable iff (RST) // R4
    s_vb_write ##0 !PRIV_WRITE |=> $stable(vec_base))
    else $error("unprivileged write moved vector base");
  AST_BASE_WINDOW: assert property (@(posedge CLK) disable iff (RST) // R4
    vec_base == 32'h0 || (vec_base >= EPV_VECBASE_MIN && vec_base <= EPV_VECBASE_MAX))
    else $error("vector base outside window");
  AST_PRIO_ZERO: assert property (@(posedge CLK) $past(RST) |-> prio[4] == 3'h0) // R7
    else $error("priority not zero after reset");
  AST_FIXED_WIN: assert property (@(posedge CLK) disable iff (RST) // R8
    pend[2] && !pend[1] |=> win_exc == EPV_EXC_NMI)
    else $error("NMI lost to a settable exception");
  AST_LOWEST_TIE: assert property (@(posedge CLK) disable iff (RST) // R9
    pend[4] && prio[4] == 3'h0 && !pend[1] && !pend[2] && !pend[3] |=> win_exc == 6'h04)
    else $error("tie not won by lowest number");
  AST_EQUAL_NO_PREEMPT: assert property (@(posedge CLK) disable iff (RST) // R11
    best_found && best_rank == act_rank |=> !win_preempt)
    else $error("equal priority preempted");
  AST_VECTOR_ADDR: assert property (@(posedge CLK) disable iff (RST) // R16
    WIN_VECTOR_ADDR == vec_base + {24'h0, win_exc, 2'b00})
    else $error("vector address wrong");
  AST_BUS_ANSWER: assert property (@(posedge CLK) disable iff (RST) // R17
    take |=> !AVS_WAITREQUEST || !(AVS_READ || AVS_WRITE))
    else $error("bus answer late");
  AST_BASE_WRITE: assert property (@(posedge CLK) disable iff (RST) // R4
    s_vb_write ##0 PRIV_WRITE && AVS_WRITEDATA == EPV_VECBASE_MIN && AVS_BYTEENABLE == 4'hF
    |=> vec_base == EPV_VECBASE_MIN)
    else $error("privileged base write lost");
  AST_FIXED_PRIO_WRITE: assert property (@(posedge CLK) disable iff (RST) // R6
    s_fixed_prio_write |=> $stable(prio[3]))
    else $error("fixed priority changed by a write");

  // arbitration checks
  AST_RESET_WINS: assert property (@(posedge CLK) disable iff (RST) // R8
    pend[1] |=> win_exc == EPV_EXC_RESET)
    else $error("reset lost arbitration");
  AST_HARD_WIN: assert property (@(posedge CLK) disable iff (RST) // R8
    pend[3] && !pend[1] && !pend[2] |=> win_exc == EPV_EXC_HARD)
    else $error("hard fault lost to a settable exception");
  AST_SPLIT_ONE: assert property (@(posedge CLK) disable iff (RST) // R12
    group_sel == 3'h1 |-> grp[16] == {prio[16][2:1], 1'b0} && sub[16] == {2'b00, prio[16][0]})
    else $error("priority split wrong");
  AST_GROUP_EQUAL: assert property (@(posedge CLK) disable iff (RST) // R13
    ACTIVE_EXC == 6'h11 && pend[16] && grp[16] == grp[17] |=> !win_preempt || win_exc != 6'h10)
    else $error("equal group preempted");
  AST_SUB_FIRST: assert property (@(posedge CLK) disable iff (RST) // R14
    pend[16] && pend[17] && pend[15:1] == 15'h0000 && (pend >> 18) == '0
    && grp[16] == grp[17] && sub[17] < sub[16] |=> win_exc == 6'h11)
    else $error("subpriority order broken");
  AST_PREEMPT_THREAD: assert property (@(posedge CLK) disable iff (RST) // R10
    s_thread_pending |=> win_preempt)
    else $error("winner did not preempt thread mode");
  AST_IDLE_NO_VALID: assert property (@(posedge CLK) disable iff (RST) // R17
    pend[NEXC-1:1] == '0 |=> !win_valid && win_exc == EPV_EXC_NONE)
    else $error("winner shown with nothing pending");
endmodule
`default_nettype wire

// *** sim/epv_core_model.sv ***
/*
  Model of the processor core: when the bench strobes take and the winner
  preempts, it takes the registered winner as its running handler, and returns to thread mode when the bench asks.
  Assumes the winner outputs of epv_top and bench strobes on CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module epv_core_model
  import epv_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic take,
  input wire logic ret,
  input wire logic [EPV_EXC_W-1:0] win_exc,
  input wire logic win_valid,
  input wire logic win_preempt,
  input wire logic [31:0] vector_addr,
  output logic [EPV_EXC_W-1:0] active_exc,
  output logic [31:0] handler_pc
);
  logic [EPV_EXC_W-1:0] next_active_exc;
  logic [31:0] next_handler_pc;
  always_comb begin
    next_active_exc = active_exc;
    next_handler_pc = handler_pc;
    if (ret) begin
      next_active_exc = EPV_EXC_NONE;
    end else if (take && win_valid && win_preempt) begin
      next_active_exc = win_exc;
      // table word modelled as its own address with bit zero set
      next_handler_pc = {vector_addr[31:1], 1'b1};
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      active_exc <= EPV_EXC_NONE;
      handler_pc <= 32'h0000_0000;
    end else begin
      active_exc <= next_active_exc;
      handler_pc <= next_handler_pc;
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
/*
  Self-checking bench for epv_top: vector base, priorities, grouping,
  arbitration and preemption.
  Assumes epv_pkg, epv_top and epv_core_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import epv_pkg::*;
;
  logic clk, rst, rd, wr, priv, take, ret, wait_req, wv, wp;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, got, vaddr, spaddr, hpc, exp_base;
  logic [3:0] be;
  logic [47:0] irq;
  logic [15:0] sysx;
  logic [5:0] act, win;
  int failures, comparisons;

  epv_top DUT (.CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .PRIV_WRITE(priv), .PERIPHERAL_INTERRUPT_LINE(irq),
    .SYS_EXC_PENDING(sysx), .ACTIVE_EXC(act), .WIN_EXC(win), .WIN_VALID(wv),
    .WIN_PREEMPT(wp), .WIN_VECTOR_ADDR(vaddr), .RESET_SP_ADDR(spaddr));
  epv_core_model core (.clk(clk), .rst(rst), .take(take), .ret(ret), .win_exc(win),
    .win_valid(wv), .win_preempt(wp), .vector_addr(vaddr), .active_exc(act),
    .handler_pc(hpc));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic complete_run;
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // entered just after a rising edge; answer taken at the edge with waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic prio(input logic [7:0] n, input logic [2:0] v);
    bus(1'b1, EPV_OFS_PRIO0 + n, {29'h0000_0000, v});
  endtask

  task automatic check_reg(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected %0t value %h, wanted %h", $time, g, e);
    end
  endtask

  // winner seen one cycle after the inputs; vector from exp_base
  task automatic check_win(input logic [5:0] e, input logic p);
    @(posedge clk);
    @(negedge clk);
    comparisons++;
    if (win !== e || wv !== 1'b1 || wp !== p
        || vaddr !== exp_base + {24'h00_0000, e, 2'b00}) begin
      failures++;
      $display("unexpected %0t winner %h preempt %b vector %h", $time, win, wp, vaddr);
    end
    @(posedge clk);
  endtask

  task automatic t_reset;
    check_reg(spaddr, 32'h0000_0000);
    bus(1'b0, EPV_OFS_VECBASE, 32'h0000_0000);
    check_reg(got, 32'h0000_0000);
    bus(1'b0, EPV_OFS_PRIO0 + 8'h10, 32'h0000_0000);
    check_reg(got & 32'h0000_0007, 32'h0000_0000);
  endtask

  task automatic t_base;
    priv <= 1'b0;
    bus(1'b1, EPV_OFS_VECBASE, 32'h0000_0200);
    bus(1'b0, EPV_OFS_VECBASE, 32'h0000_0000);
    check_reg(got, 32'h0000_0000);
    priv <= 1'b1;
    bus(1'b1, EPV_OFS_VECBASE, 32'h4000_0000);
    bus(1'b0, EPV_OFS_VECBASE, 32'h0000_0000);
    check_reg(got, 32'h0000_0000);
    bus(1'b1, EPV_OFS_VECBASE, 32'h0000_0100);
    bus(1'b0, EPV_OFS_VECBASE, 32'h0000_0000);
    check_reg(got, 32'h0000_0100);
    bus(1'b1, EPV_OFS_VECBASE, 32'h3FFF_FF00);
    bus(1'b0, EPV_OFS_VECBASE, 32'h0000_0000);
    check_reg(got, 32'h3FFF_FF00);
    check_reg(spaddr, 32'h3FFF_FF00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, EPV_OFS_VECBASE, 32'h0000_0000);
    check_reg(got, 32'h0000_0000);
  endtask

  task automatic t_order;
    irq <= 48'h0000_0000_0003;
    check_win(6'h10, 1'b1);
    prio(8'h10, 3'h5);
    prio(8'h11, 3'h2);
    check_win(6'h11, 1'b1);
    sysx <= 16'h0004;
    check_win(6'h02, 1'b1);
    sysx <= 16'h0000;
    irq <= 48'h0000_0000_0002;
    check_win(6'h11, 1'b1);
  endtask

  task automatic t_fixed;
    prio(8'h03, 3'h7);
    bus(1'b0, EPV_OFS_PRIO0 + 8'h03, 32'h0000_0000);
    check_reg(got, EPV_UNMAPPED_DATA);
    sysx <= 16'h0038;
    check_win(6'h03, 1'b1);
    sysx <= 16'h0030;
    check_win(6'h04, 1'b1);
    sysx <= 16'h0002;
    check_win(6'h01, 1'b1);
  endtask

  task automatic t_vector;
    bus(1'b1, EPV_OFS_VECBASE, 32'h0000_0100);
    exp_base = 32'h0000_0100;
    sysx <= 16'h0000;
    irq <= 48'h0000_0000_0020;
    check_win(6'h15, 1'b1);
    bus(1'b0, EPV_OFS_STATUS, 32'h0000_0000);
    check_reg(got, 32'h0000_00D5);
    bus(1'b0, EPV_OFS_GROUP, 32'h0000_0000);
    check_reg(got, 32'h0000_0001);
    check_reg(spaddr, 32'h0000_0100);
    irq <= 48'h0000_0000_0000;
    @(posedge clk);
    @(negedge clk);
    check_reg({25'h000_0000, wv, win}, 32'h0000_0000);
    @(posedge clk);
  endtask

  task automatic t_preempt;
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    irq <= 48'h0000_0000_0001;
    check_win(6'h10, 1'b0);
    check_reg(hpc, 32'h0000_0045);
    prio(8'h10, 3'h2);
    check_win(6'h10, 1'b0);
    prio(8'h10, 3'h1);
    check_win(6'h10, 1'b1);
    prio(8'h10, 3'h3);
    bus(1'b1, EPV_OFS_GROUP, 32'h0000_0001);
    check_win(6'h10, 1'b0);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    irq <= 48'h0000_0000_0003;
    check_win(6'h11, 1'b1);
    prio(8'h10, 3'h2);
    check_win(6'h10, 1'b1);
  endtask

  initial begin
    failures = 0;
    comparisons = 0;
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    priv = 1'b1;
    take = 1'b0;
    ret = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    be = 4'hF;
    irq = 48'h0000_0000_0000;
    sysx = 16'h0000;
    exp_base = 32'h0000_0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_base();
    t_order();
    t_preempt();
    t_fixed();
    t_vector();
    complete_run();
  end

  initial begin
    repeat (10000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
